// File: core/dsf_host.sv
// Host-side controller driving one port of a dual-port semaphore unit
//
// Contract
// RULE_01: Device has eight semaphore latches apart from the memory array.
// RULE_02: Semaphore select low plus address, output enable, read/write.
// RULE_03: Only the three lowest address bits pick the latch.
// RULE_04: Only data bit zero is taken on a semaphore write.
// RULE_05: Flags active low; write zero requests, write one releases.
// RULE_06: Zero to a free flag reads zero here, one on the other side.
// RULE_07: Owner writing one frees the flag unless the other side pends.
// RULE_08: Non-owner zero waits in its request latch until release.
// RULE_09: Pending request takes ownership at once on release.
// RULE_10: Read drives the flag onto every data bit.
// RULE_11: Read value latched while select and output enable stay active.
// RULE_12: Polling must drop select or output enable between reads.
// RULE_13: Request by writing zero first, then read back.
// RULE_14: Near-simultaneous requests grant one port, the earlier one.
// RULE_15: Exactly coincident requests still grant one port only.
// RULE_16: After failure keep re-reading or write one to withdraw.
// RULE_17: Software writes one to every latch from both ports at start.
// RULE_18: Port idles when array and semaphore selects are both high.
// RULE_19: Semaphores never stall memory or add wait states.
// RULE_20: Zero from non-owner leaves both read values unchanged.
// RULE_21: Asynchronous requests resolved by a mutual-exclusion element.
`timescale 1ns/10ps
`default_nettype none
module dsf_host (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire logic                       cmdValid,
    output logic                            cmdReady,
    input  wire logic                       cmdWrite,
    input  wire logic [2:0]                 cmdIndex,
    input  wire logic                       cmdValue,
    input  wire logic                       initStart,
    output logic                            initBusy,
    output logic                            rspValid,
    output logic                            rspOwned,
    output logic                            chipSelectN,
    output logic                            semaphore_select_n,
    output logic                            outputEnableN,
    output logic                            readWriteN,
    output logic [dsf_pkg::ADDR_WIDTH-1:0]  address,
    input  wire logic [dsf_pkg::DATA_WIDTH-1:0] dataIn,
    output logic [dsf_pkg::DATA_WIDTH-1:0]  dataOut,
    output logic                            dataOutEn
);
    dsf_pkg::dsf_state_e state;
    dsf_pkg::dsf_state_e next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    logic       isWrite;
    logic       next_isWrite;
    logic       isInit;
    logic       next_isInit;
    logic [2:0] index;
    logic [2:0] next_index;
    logic       value;
    logic       next_value;
    logic       next_rspValid;
    logic       next_rspOwned;

    // Expands the written bit to a full data byte
    function automatic logic [dsf_pkg::DATA_WIDTH-1:0] spread(
        input logic bitValue);
        spread = {dsf_pkg::DATA_WIDTH{bitValue}};
    endfunction : spread

    always_comb begin
        next_state    = state;
        next_count    = count;
        next_isWrite  = isWrite;
        next_isInit   = isInit;
        next_index    = index;
        next_value    = value;
        next_rspValid = 1'b0;
        next_rspOwned = rspOwned;
        case (state)
            dsf_pkg::DSF_IDLE: begin
                if (initStart) begin
                    // Free every latch from this port at start  // see RULE_17
                    next_isInit  = 1'b1;
                    next_isWrite = 1'b1;
                    next_index   = 3'h0;
                    next_value   = dsf_pkg::FLAG_FREE;
                    next_count   = dsf_pkg::SETUP_CYCLES;
                    next_state   = dsf_pkg::DSF_SETUP;
                end else if (cmdValid) begin
                    next_isWrite = cmdWrite;
                    next_index   = cmdIndex;  // see RULE_03
                    next_value   = cmdValue;  // see RULE_05
                    next_count   = dsf_pkg::SETUP_CYCLES;
                    next_state   = dsf_pkg::DSF_SETUP;
                end
            end
            dsf_pkg::DSF_SETUP: begin
                if (count <= 4'h1) begin
                    next_count = dsf_pkg::STROBE_CYCLES;
                    next_state = dsf_pkg::DSF_STROBE;
                end else begin
                    next_count = count - 4'h1;
                end
            end
            dsf_pkg::DSF_STROBE: begin
                if (count <= 4'h1) begin
                    if (!isWrite) begin
                        // A zero on data bit zero means this port holds it
                        next_rspValid = 1'b1;  // see RULE_10
                        next_rspOwned =
                            (dataIn[dsf_pkg::OWNED_BIT] == dsf_pkg::FLAG_TAKE);
                    end else if (!isInit) begin
                        next_rspValid = 1'b1;
                        next_rspOwned = 1'b0;
                    end
                    next_count = dsf_pkg::RECOVER_CYCLES;
                    next_state = dsf_pkg::DSF_RECOVER;
                end else begin
                    next_count = count - 4'h1;
                end
            end
            dsf_pkg::DSF_RECOVER: begin
                // Selects go high between accesses  // see RULE_12
                if (count <= 4'h1) begin
                    if (isInit && index != 3'h7) begin
                        next_index = index + 3'h1;  // see RULE_01
                        next_count = dsf_pkg::SETUP_CYCLES;
                        next_state = dsf_pkg::DSF_SETUP;
                    end else begin
                        next_isInit = 1'b0;
                        next_state  = dsf_pkg::DSF_IDLE;
                    end
                end else begin
                    next_count = count - 4'h1;
                end
            end
            default: begin
                next_isInit = 1'b0;
                next_state  = dsf_pkg::DSF_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state    <= dsf_pkg::DSF_IDLE;
            count    <= 4'h0;
            isWrite  <= 1'b0;
            isInit   <= 1'b0;
            index    <= 3'h0;
            value    <= 1'b1;
            rspValid <= 1'b0;
            rspOwned <= 1'b0;
        end else begin
            state    <= next_state;
            count    <= next_count;
            isWrite  <= next_isWrite;
            isInit   <= next_isInit;
            index    <= next_index;
            value    <= next_value;
            rspValid <= next_rspValid;
            rspOwned <= next_rspOwned;
        end
    end

    logic active;
    logic strobe;
    logic [dsf_pkg::DATA_WIDTH-1:0] next_dataOut;
    always_comb begin
        active       = (state == dsf_pkg::DSF_SETUP) ||
                       (state == dsf_pkg::DSF_STROBE);
        strobe       = (state == dsf_pkg::DSF_STROBE);
        // Data follows the value being launched, not the previous one
        next_dataOut = spread(next_value);  // see RULE_04
    end

    logic                           next_semN;
    logic                           next_oeN;
    logic                           next_rwN;
    logic                           next_doEn;
    logic [dsf_pkg::ADDR_WIDTH-1:0] next_address;
    always_comb begin
        // Array select held high so the port uses semaphore space only
        next_semN    = !(next_state == dsf_pkg::DSF_SETUP ||
                         next_state == dsf_pkg::DSF_STROBE);  // see RULE_02
        next_oeN     = !((next_state == dsf_pkg::DSF_SETUP ||
                          next_state == dsf_pkg::DSF_STROBE) &&
                         !next_isWrite);  // see RULE_11
        next_rwN     = !(next_state == dsf_pkg::DSF_STROBE && next_isWrite);
        next_doEn    = (next_state == dsf_pkg::DSF_SETUP ||
                        next_state == dsf_pkg::DSF_STROBE) && next_isWrite;
        next_address = {{(dsf_pkg::ADDR_WIDTH-3){1'b0}}, next_index};
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            chipSelectN        <= 1'b1;  // see RULE_18
            semaphore_select_n <= 1'b1;
            outputEnableN      <= 1'b1;
            readWriteN         <= 1'b1;
            dataOutEn          <= 1'b0;
            address            <= '0;
            dataOut            <= 8'hff;
        end else begin
            chipSelectN        <= 1'b1;
            semaphore_select_n <= next_semN;
            outputEnableN      <= next_oeN;
            readWriteN         <= next_rwN;
            dataOutEn          <= next_doEn;
            address            <= next_address;
            dataOut            <= next_dataOut;
        end
    end

    // Every access ends with selects high, so re-reads and withdrawals work
    // Caller retries by reading or frees by writing one  // see RULE_16
    // Request handshake; write-then-read is left to the caller  // see RULE_13
    always_comb begin
        cmdReady = (state == dsf_pkg::DSF_IDLE) && !initStart;
        initBusy = isInit || (active && strobe && isInit);
    end
endmodule : dsf_host
`default_nettype wire

// File: include/dsf_pkg.sv
// Package of constants for the semaphore port controller
package dsf_pkg;
    localparam int          FLAG_COUNT   = 8;
    localparam int          INDEX_WIDTH  = 3;
    localparam int          ADDR_WIDTH   = 13;
    localparam int          DATA_WIDTH   = 8;
    localparam int          OWNED_BIT    = 0;
    localparam logic        FLAG_TAKE    = 1'b0;
    localparam logic        FLAG_FREE    = 1'b1;
    // Access phase lengths in ns and derived cycle counts at 40 MHz
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          SETUP_NS        = 25;
    localparam int          STROBE_NS       = 50;
    localparam int          RECOVER_NS      = 25;
    localparam logic [3:0]  SETUP_CYCLES    =
        4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0]  STROBE_CYCLES   =
        4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0]  RECOVER_CYCLES  =
        4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        DSF_IDLE    = 3'b000,
        DSF_SETUP   = 3'b001,
        DSF_STROBE  = 3'b011,
        DSF_RECOVER = 3'b010,
        DSF_INIT    = 3'b110
    } dsf_state_e;
endpackage : dsf_pkg

// File: tb/dsf_device_model.sv
// Behavioural model of the semaphore unit, host port plus far port
`timescale 1ns/10ps
`default_nettype none
module dsf_device_model (
    input wire logic        sys_clk,
    input wire logic        semN,
    input wire logic        oeN,
    input wire logic        rwN,
    input wire logic [2:0]  idx,
    input wire logic        wBit,
    output logic     [7:0]  rdData,
    input wire logic        otherWe,
    input wire logic [2:0]  otherIdx,
    input wire logic        otherVal,
    output logic     [7:0]  otherView
);
    logic [7:0] reqH = 8'h00, reqO = 8'hff, ownH = 8'h00, ownO = 8'h00;
    logic       hold = 1'b1;
    logic       sel  = 1'b0;
    always @(posedge sys_clk) begin
        if (!semN && !rwN) reqH[idx] = wBit;
        if (otherWe) reqO[otherIdx] = otherVal;
        for (int i = 0; i < 8; i++) begin
            if (reqH[i]) ownH[i] = 1'b0;
            if (reqO[i]) ownO[i] = 1'b0;
            if (!ownH[i] && !ownO[i]) begin
                ownH[i] = !reqH[i];
                ownO[i] = reqH[i] && !reqO[i];
            end
        end
        // Capture once per select, after this edge's ownership update
        if (!semN && !oeN && !sel) hold = !ownH[idx];
        sel = !semN && !oeN;
    end
    assign rdData = {8{(!semN && !oeN) ? hold : !hold}};
    assign otherView = ~ownO;
endmodule : dsf_device_model
`default_nettype wire

// File: tb/dsf_host_sva.sv
// Checker for the semaphore port controller
`timescale 1ns/10ps
`default_nettype none
module dsf_host_sva (
    input wire logic                               sys_clk,
    input wire logic                               reset,
    input wire logic                               cmdReady,
    input wire logic                               initBusy,
    input wire logic                               rspValid,
    input wire logic                               rspOwned,
    input wire logic                               chipSelectN,
    input wire logic                               semaphore_select_n,
    input wire logic                               outputEnableN,
    input wire logic                               readWriteN,
    input wire logic [dsf_pkg::ADDR_WIDTH-1:0]     address,
    input wire logic [dsf_pkg::DATA_WIDTH-1:0]     dataIn,
    input wire logic [dsf_pkg::DATA_WIDTH-1:0]     dataOut,
    input wire logic                               dataOutEn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_sel; !semaphore_select_n [*3] ##1 semaphore_select_n; endsequence
    sequence s_oe; !outputEnableN [*3] ##1 outputEnableN; endsequence
    property p_sel; $fell(semaphore_select_n) |-> s_sel; endproperty
    a_sel: assert property (p_sel) else $error("select length");
    property p_oe; $fell(outputEnableN) |-> s_oe; endproperty
    a_oe: assert property (p_oe) else $error("oe held");
    property p_cs; chipSelectN; endproperty
    a_cs: assert property (p_cs) else $error("array selected");
    property p_rw;
        !readWriteN |-> !semaphore_select_n && outputEnableN && dataOutEn;
    endproperty
    a_rw: assert property (p_rw) else $error("write strobe");
    property p_adr; !semaphore_select_n |-> address[12:3] == 10'h000; endproperty
    a_adr: assert property (p_adr) else $error("high address");
    property p_dat; dataOutEn |-> dataOut == {8{dataOut[0]}}; endproperty
    a_dat: assert property (p_dat) else $error("data spread");
    property p_ini; initBusy && dataOutEn |-> dataOut == 8'hff; endproperty
    a_ini: assert property (p_ini) else $error("init value");
    property p_rsp;
        rspValid |-> semaphore_select_n && $past(!semaphore_select_n);
    endproperty
    a_rsp: assert property (p_rsp) else $error("answer timing");
    property p_own;
        rspValid && $past(!outputEnableN) |-> rspOwned == !$past(dataIn[0]);
    endproperty
    a_own: assert property (p_own) else $error("owned value");
    property p_wro; rspValid && $past(outputEnableN) |-> !rspOwned; endproperty
    a_wro: assert property (p_wro) else $error("write answer");
    property p_idl; cmdReady |-> semaphore_select_n && outputEnableN; endproperty
    a_idl: assert property (p_idl) else $error("idle pins");
endmodule : dsf_host_sva
bind dsf_host dsf_host_sva u_sva (.sys_clk, .reset, .cmdReady, .initBusy,
    .rspValid, .rspOwned, .chipSelectN, .semaphore_select_n, .outputEnableN,
    .readWriteN, .address, .dataIn, .dataOut, .dataOutEn);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking testbench for the semaphore port controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        sys_clk = 0, reset = 1, cmdValid = 0, cmdWrite = 0;
    logic        cmdValue = 0, initStart = 0, otherWe = 0, otherVal = 1, own;
    logic [2:0]  cmdIndex = 0, otherIdx = 0;
    wire logic   cmdReady, initBusy, rspValid, rspOwned, csN, semN, oeN, rwN;
    wire logic   dataOutEn;
    wire logic [12:0] address;
    wire logic [7:0]  dataIn, dataOut, otherView;
    int          miscompares = 0, samples_checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    dsf_host dut (.sys_clk, .reset, .cmdValid, .cmdReady, .cmdWrite, .cmdIndex,
        .cmdValue, .initStart, .initBusy, .rspValid, .rspOwned,
        .chipSelectN(csN), .semaphore_select_n(semN), .outputEnableN(oeN),
        .readWriteN(rwN), .address, .dataIn, .dataOut, .dataOutEn);
    dsf_device_model u_dev (.sys_clk, .semN, .oeN, .rwN, .idx(address[2:0]),
        .wBit(dataOut[0]), .rdData(dataIn), .otherWe, .otherIdx, .otherVal,
        .otherView);
    task tick; @(posedge sys_clk); #2; endtask : tick
    task check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task close_out;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    function automatic logic pick(input int sel);
        case (sel)
            0:       pick = cmdReady;
            1:       pick = rspValid;
            default: pick = initBusy;
        endcase
    endfunction : pick
    task waitfor(input int sel, input logic want);
        for (int n = 0; pick(sel) !== want; n++) begin
            if (n > 60) begin miscompares++; close_out; end
            tick;
        end
    endtask : waitfor
    task access(input logic w, input logic [2:0] i, input logic v);
        waitfor(0, 1'b1);
        cmdValid = 1; cmdWrite = w; cmdIndex = i; cmdValue = v;
        tick;
        cmdValid = 0;
        waitfor(1, 1'b1);
        own = rspOwned;
    endtask : access
    task other(input logic [2:0] i, input logic v);
        otherWe = 1; otherIdx = i; otherVal = v;
        tick;
        otherWe = 0;
    endtask : other
    task t_init;
        access(0, 3'h4, 0);
        check({7'h0, own}, 8'h01);
        waitfor(0, 1'b1);
        initStart = 1;
        tick;
        initStart = 0;
        waitfor(2, 1'b0);
        for (int i = 0; i < 8; i++) begin
            access(0, i[2:0], 0);
            check({7'h0, own}, 8'h00);
        end
    endtask : t_init
    task t_take;
        access(1, 3'h5, 0);
        access(0, 3'h5, 0);
        check({7'h0, own}, 8'h01);
        check(otherView, 8'hff);
        other(3'h5, 0);
        access(0, 3'h5, 0);
        check({7'h0, own}, 8'h01);
        check(otherView, 8'hff);
        access(1, 3'h5, 1);
        access(0, 3'h5, 0);
        check({7'h0, own}, 8'h00);
        check(otherView, 8'hdf);
        other(3'h5, 1);
        check(otherView, 8'hff);
        access(0, 3'h5, 0);
        check({7'h0, own}, 8'h00);
    endtask : t_take
    task t_race;
        other(3'h2, 0);
        access(1, 3'h2, 0);
        access(0, 3'h2, 0);
        check({7'h0, own}, 8'h00);
        other(3'h2, 1);
        access(0, 3'h2, 0);
        check({7'h0, own}, 8'h01);
        access(1, 3'h2, 1);
        access(0, 3'h2, 0);
        check({7'h0, own}, 8'h00);
    endtask : t_race
    initial begin
        repeat (16) tick;
        reset = 0;
        t_init;
        t_take;
        t_race;
        close_out;
    end
endmodule : testbench
`default_nettype wire
